// >>> wpf_pkg.sv
package wpf_pkg;

   // Program store geometry.
   localparam int NUM_PROGS = 19;
   localparam int PIDX_W    = 5;
   localparam int TMR_W     = 16;
   localparam int NFLAG     = 8;
   localparam int NSW       = 9;

   // Feature flag positions, one per selector switch.
   localparam int FLG_TACK   = 0;
   localparam int FLG_AUTO   = 1;
   localparam int FLG_ZSRCH  = 2;
   localparam int FLG_SIDE   = 3;
   localparam int FLG_VDLY   = 4;
   localparam int FLG_HDLY   = 5;
   localparam int FLG_LOCK   = 6;
   localparam int FLG_CRATER = 7;

   // Timer slot selectors.
   localparam logic [1:0] TSEL_WELD    = 2'h0;
   localparam logic [1:0] TSEL_OVERLAP = 2'h1;
   localparam logic [1:0] TSEL_FINAL   = 2'h2;
   localparam logic [1:0] TSEL_RETRACT = 2'h3;

   // Timing; timers count in tenths of a second.
   localparam int CLK_PERIOD_NS   = 100;
   localparam int TENTH_NS        = 100_000_000;
   localparam int TENTH_CYCLES    = TENTH_NS / CLK_PERIOD_NS;
   localparam int DEBOUNCE_NS     = 10_000_000;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_NS / CLK_PERIOD_NS;
   localparam int TENTHS_PER_S    = 10;
   localparam int DEF_WELD_S      = 60;
   localparam int CRATER_S        = 2;
   localparam logic [TMR_W-1:0] DEF_WELD_T = TMR_W'(DEF_WELD_S * TENTHS_PER_S);
   localparam logic [TMR_W-1:0] CRATER_T   = TMR_W'(CRATER_S * TENTHS_PER_S);

   // Register offsets and fields.
   localparam logic [7:0] REG_PROG_SEL  = 8'h00;
   localparam logic [7:0] REG_TIMER_VAL = 8'h04;
   localparam logic [7:0] REG_STATUS    = 8'h08;
   localparam logic [7:0] REG_REMAIN    = 8'h0c;
   localparam int PS_ACTIVE_LSB = 0;
   localparam int PS_EDIT_LSB   = 8;
   localparam int PS_TSEL_LSB   = 16;
   localparam int ST_DIFF_LSB   = 8;
   localparam int ST_PEND_BIT   = 16;
   localparam int ST_ARMED_BIT  = 17;
   localparam int ST_STATE_LSB  = 20;
   localparam logic [PIDX_W-1:0] RST_PROG     = 5'h00;
   localparam logic [1:0]        RST_TSEL     = 2'h0;
   localparam logic [TMR_W-1:0]  RST_TIMER_VAL = 16'h0000;

   // Factory defaults per program, entry 0 is program 1.
   localparam logic [7:0] DEF_FLAGS [NUM_PROGS] = '{
      8'h81, 8'hb5, 8'hbc, 8'h00, 8'hb4, 8'hc0, 8'h84, 8'h8c, 8'hbd, 8'h8d,
      8'hb7, 8'h8e, 8'hb6, 8'hbe, 8'h86, 8'hc2, 8'h8f, 8'h83, 8'hbf};
   localparam logic [7:0] DEF_OVERLAP [NUM_PROGS] = '{
      8'h00, 8'h00, 8'h00, 8'h32, 8'h00, 8'h14, 8'h00, 8'h00, 8'h05, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1e, 8'h00, 8'h00, 8'h0a};
   localparam logic [7:0] DEF_FINAL [NUM_PROGS] = '{
      8'h0a, 8'h14, 8'h1e, 8'h28, 8'h32, 8'h32, 8'h32, 8'h32, 8'h32, 8'h32,
      8'h32, 8'h32, 8'h32, 8'h32, 8'h32, 8'h32, 8'h32, 8'h32, 8'h32};
   localparam logic [7:0] DEF_RETRACT [NUM_PROGS] = '{
      8'h05, 8'h0a, 8'h14, 8'h1e, 8'h28, 8'h32, 8'h64, 8'h32, 8'h32, 8'h32,
      8'h32, 8'h32, 8'h32, 8'h32, 8'h32, 8'h32, 8'h32, 8'h32, 8'h32};

   // Weld cycle phases.
   typedef enum logic [2:0] {
      ST_IDLE, ST_SEEK, ST_WELD, ST_AUTO,
      ST_OVERLAP, ST_FINAL, ST_CRATER, ST_RETRACT
   } wpf_state_type;

endpackage

// >>> wpf_debounce.sv
`timescale 1ns/100ps
module wpf_debounce
   import wpf_pkg::*;
#(
   parameter int W   = 1,
   parameter int CYC = DEBOUNCE_CYCLES
) (
   input  wire logic         ref_clk_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] raw_in,
   output logic      [W-1:0] clean_out
);

   localparam int CW = $clog2(CYC + 1);

   // Each input is synchronised, then must hold still for CYC cycles.
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic          sync1_ff;
      logic          sync2_ff;
      logic [CW-1:0] cnt_ff;
      logic          clean_ff;

      always_ff @(posedge ref_clk_in) begin
         if (!rst_n_in) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            cnt_ff   <= '0;
            clean_ff <= 1'b0;
         end else begin
            sync1_ff <= raw_in[i];
            sync2_ff <= sync1_ff;
            if (sync2_ff == clean_ff) begin
               cnt_ff <= '0;
            end else if (cnt_ff == CW'(CYC - 1)) begin
               cnt_ff   <= '0;
               clean_ff <= sync2_ff;
            end else begin
               cnt_ff <= cnt_ff + 1'b1;
            end
         end
      end

      assign clean_out[i] = clean_ff;
   end

endmodule

// >>> wpf_prog_mem.sv
`timescale 1ns/100ps
module wpf_prog_mem
   import wpf_pkg::*;
(
   input  wire logic              ref_clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              wr_en_in,
   input  wire logic [PIDX_W-1:0] wr_idx_in,
   input  wire logic [1:0]        wr_tsel_in,
   input  wire logic [TMR_W-1:0]  wr_time_in,
   input  wire logic [NFLAG-1:0]  wr_flags_in,
   input  wire logic [PIDX_W-1:0] run_idx_in,
   input  wire logic [PIDX_W-1:0] edit_idx_in,
   output logic      [TMR_W-1:0]  run_tmr_out [4],
   output logic      [NFLAG-1:0]  run_flags_out,
   output logic      [NFLAG-1:0]  edit_flags_out
);

   logic [TMR_W-1:0] tmr_ff   [NUM_PROGS][4];
   logic [NFLAG-1:0] flags_ff [NUM_PROGS];

   // factory defaults at reset
   // Each entry takes one timer plus all flags on a commit.
   for (genvar p = 0; p < NUM_PROGS; p++) begin : g_prog
      always_ff @(posedge ref_clk_in) begin
         if (!rst_n_in) begin
            tmr_ff[p][TSEL_WELD]    <= DEF_WELD_T;
            tmr_ff[p][TSEL_OVERLAP] <= TMR_W'(DEF_OVERLAP[p]);
            tmr_ff[p][TSEL_FINAL]   <= TMR_W'(DEF_FINAL[p]);
            tmr_ff[p][TSEL_RETRACT] <= TMR_W'(DEF_RETRACT[p]);
            flags_ff[p]             <= DEF_FLAGS[p];
         end else if (wr_en_in && wr_idx_in == PIDX_W'(p)) begin
            tmr_ff[p][wr_tsel_in] <= wr_time_in;
            flags_ff[p]           <= wr_flags_in;
         end
      end
   end

   // Read ports; indices are kept in range by the writer.
   assign run_tmr_out    = tmr_ff[run_idx_in];
   assign run_flags_out  = flags_ff[run_idx_in];
   assign edit_flags_out = flags_ff[edit_idx_in];

endmodule

// >>> wpf_feature_ctrl.sv
`timescale 1ns/100ps
module wpf_feature_ctrl
   import wpf_pkg::*;
#(
   parameter int TENTH_CYC = TENTH_CYCLES,
   parameter int DEB_CYC   = DEBOUNCE_CYCLES
) (
   input  wire logic             ref_clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [7:0]       addr_in,
   input  wire logic [31:0]      wr_data_in,
   input  wire logic             wr_strobe_in,
   input  wire logic             rd_strobe_in,
   output logic      [31:0]      rd_data_out,
   input  wire logic             prog_button_in,
   input  wire logic [NFLAG-1:0] feature_select_switch_bank_in,
   input  wire logic             cycle_start_in,
   input  wire logic             cycle_stop_in,
   input  wire logic             sensor_null_in,
   input  wire logic             sensor_up_in,
   input  wire logic             sensor_down_in,
   input  wire logic             tack_detect_in,
   input  wire logic             tack_arm_toggle_in,
   output logic                  weld_on_out,
   output logic                  overlap_out,
   output logic                  final_out,
   output logic                  crater_out,
   output logic                  retract_out,
   output logic                  tack_armed_out,
   output logic                  slide_lockout_out,
   output logic                  sidetrack_en_out,
   output logic                  z_search_en_out,
   output logic                  vsearch_delay_en_out,
   output logic                  hretract_delay_en_out,
   output logic                  settle_lockout_en_out,
   output logic      [NFLAG-1:0] features_differ_out
);

   localparam int TCW = $clog2(TENTH_CYC + 1);

   logic [NSW-1:0]    raw_sw;
   logic [NSW-1:0]    clean_sw;
   logic [NFLAG-1:0]  sw_flags;
   logic              btn_db;
   logic              btn_q_ff;
   logic              press;
   logic              commit;
   logic              pend_ff;
   logic [PIDX_W-1:0] active_ff;
   logic [PIDX_W-1:0] edit_ff;
   logic [1:0]        tsel_ff;
   logic [TMR_W-1:0]  tval_ff;
   logic [PIDX_W-1:0] run_idx_ff;
   logic [TMR_W-1:0]  run_tmr [4];
   logic [NFLAG-1:0]  run_flags;
   logic [NFLAG-1:0]  edit_flags;
   logic [TCW-1:0]    tcnt_ff;
   logic              tick_ff;
   wpf_state_type     state_ff;
   wpf_state_type     nxt_state;
   logic [TMR_W-1:0]  remain_ff;
   logic [TMR_W-1:0]  nxt_remain;
   logic              tack_done_ff;
   logic [31:0]       rd_mux;
   logic [PIDX_W-1:0] wr_active;
   logic [PIDX_W-1:0] wr_edit;

   assign raw_sw = {prog_button_in, feature_select_switch_bank_in};

   wpf_debounce #(
      .W   (NSW),
      .CYC (DEB_CYC)
   ) u_debounce (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .raw_in     (raw_sw),
      .clean_out  (clean_sw)
   );

   assign sw_flags = clean_sw[NFLAG-1:0];
   assign btn_db   = clean_sw[NFLAG];

   wpf_prog_mem u_mem (
      .ref_clk_in     (ref_clk_in),
      .rst_n_in       (rst_n_in),
      .wr_en_in       (commit),
      .wr_idx_in      (edit_ff),
      .wr_tsel_in     (tsel_ff),
      .wr_time_in     (tval_ff),
      .wr_flags_in    (sw_flags),
      .run_idx_in     (run_idx_ff),
      .edit_idx_in    (edit_ff),
      .run_tmr_out    (run_tmr),
      .run_flags_out  (run_flags),
      .edit_flags_out (edit_flags)
   );

   // Button press edge after debouncing.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         btn_q_ff <= 1'b0;
      end else begin
         btn_q_ff <= btn_db;
      end
   end

   assign press = btn_db & ~btn_q_ff;

   assign commit = press & (pend_ff | (sw_flags == edit_flags));

   // A press with differing switches only stages; the next press stores.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         pend_ff <= 1'b0;
      end else if (commit) begin
         pend_ff <= 1'b0;
      end else if (press) begin
         pend_ff <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         features_differ_out <= '0;
      end else if (pend_ff && !commit) begin
         features_differ_out <= sw_flags ^ edit_flags;
      end else begin
         features_differ_out <= '0;
      end
   end

   // Program indices out of range are ignored on write.
   assign wr_active = wr_data_in[PS_ACTIVE_LSB +: PIDX_W];
   assign wr_edit   = wr_data_in[PS_EDIT_LSB +: PIDX_W];

   // Software-written selection and displayed timer value.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         active_ff <= RST_PROG;
         edit_ff   <= RST_PROG;
         tsel_ff   <= RST_TSEL;
         tval_ff   <= RST_TIMER_VAL;
      end else if (wr_strobe_in) begin
         if (addr_in == REG_PROG_SEL) begin
            if (wr_active < PIDX_W'(NUM_PROGS)) begin
               active_ff <= wr_active;
            end
            if (wr_edit < PIDX_W'(NUM_PROGS)) begin
               edit_ff <= wr_edit;
            end
            tsel_ff <= wr_data_in[PS_TSEL_LSB +: 2];
         end else if (addr_in == REG_TIMER_VAL) begin
            tval_ff <= wr_data_in[TMR_W-1:0];
         end
      end
   end

   // Read mux; unmapped addresses read zero.
   always_comb begin
      rd_mux = '0;
      unique case (addr_in)
         REG_PROG_SEL: begin
            rd_mux[PS_ACTIVE_LSB +: PIDX_W] = active_ff;
            rd_mux[PS_EDIT_LSB +: PIDX_W]   = edit_ff;
            rd_mux[PS_TSEL_LSB +: 2]        = tsel_ff;
         end
         REG_TIMER_VAL: begin
            rd_mux[TMR_W-1:0] = tval_ff;
         end
         REG_STATUS: begin
            rd_mux[NFLAG-1:0]             = run_flags;
            rd_mux[ST_DIFF_LSB +: NFLAG]  = features_differ_out;
            rd_mux[ST_PEND_BIT]           = pend_ff;
            rd_mux[ST_ARMED_BIT]          = tack_armed_out;
            rd_mux[ST_STATE_LSB +: 3]     = state_ff;
         end
         REG_REMAIN: begin
            rd_mux[TMR_W-1:0] = remain_ff;
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         rd_data_out <= '0;
      end else begin
         rd_data_out <= rd_strobe_in ? rd_mux : '0;
      end
   end

   // Tenth-of-second enable pulse for the phase timers.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         tcnt_ff <= '0;
         tick_ff <= 1'b0;
      end else if (tcnt_ff == TCW'(TENTH_CYC - 1)) begin
         tcnt_ff <= '0;
         tick_ff <= 1'b1;
      end else begin
         tcnt_ff <= tcnt_ff + 1'b1;
         tick_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         run_idx_ff <= RST_PROG;
      end else if (state_ff == ST_IDLE) begin
         run_idx_ff <= active_ff;
      end
   end

   // Weld cycle sequencing.
   always_comb begin
      nxt_state  = state_ff;
      nxt_remain = remain_ff;
      if (tick_ff && remain_ff != '0) begin
         nxt_remain = remain_ff - 1'b1;
      end
      unique case (state_ff)
         ST_IDLE: begin
            if (cycle_start_in) begin
               nxt_state = ST_SEEK;
            end
         end
         ST_SEEK: begin
            if (sensor_null_in) begin
               nxt_state  = ST_WELD;
               nxt_remain = run_tmr[TSEL_WELD];
            end
         end
         ST_WELD: begin
            if (remain_ff == '0) begin
               if (run_flags[FLG_AUTO]) begin
                  nxt_state = ST_AUTO;
               end else begin
                  nxt_state  = ST_OVERLAP;
                  nxt_remain = run_tmr[TSEL_OVERLAP];
               end
            end
         end
         ST_AUTO: begin
            if (sensor_up_in || sensor_down_in) begin
               nxt_state  = ST_OVERLAP;
               nxt_remain = run_tmr[TSEL_OVERLAP];
            end
         end
         ST_OVERLAP: begin
            if (remain_ff == '0) begin
               nxt_state  = ST_FINAL;
               nxt_remain = run_tmr[TSEL_FINAL];
            end
         end
         ST_FINAL: begin
            if (remain_ff == '0) begin
               if (run_flags[FLG_CRATER]) begin
                  nxt_state  = ST_CRATER;
                  nxt_remain = CRATER_T;
               end else begin
                  nxt_state  = ST_RETRACT;
                  nxt_remain = run_tmr[TSEL_RETRACT];
               end
            end
         end
         ST_CRATER: begin
            if (remain_ff == '0) begin
               nxt_state  = ST_RETRACT;
               nxt_remain = run_tmr[TSEL_RETRACT];
            end
         end
         ST_RETRACT: begin
            if (remain_ff == '0) begin
               nxt_state = ST_IDLE;
            end
         end
      endcase
      if (cycle_stop_in) begin
         nxt_state  = ST_IDLE;
         nxt_remain = '0;
      end
   end

   // Phase state and its countdown.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         state_ff  <= ST_IDLE;
         remain_ff <= '0;
      end else begin
         state_ff  <= nxt_state;
         remain_ff <= nxt_remain;
      end
   end

   // Phase outputs, registered.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         weld_on_out <= 1'b0;
         overlap_out <= 1'b0;
         final_out   <= 1'b0;
         crater_out  <= 1'b0;
         retract_out <= 1'b0;
      end else begin
         weld_on_out <= (state_ff == ST_WELD) || (state_ff == ST_AUTO);
         overlap_out <= state_ff == ST_OVERLAP;
         final_out   <= state_ff == ST_FINAL;
         crater_out  <= state_ff == ST_CRATER;
         retract_out <= state_ff == ST_RETRACT;
      end
   end

   // Tack arming: automatic once per cycle at null, manual toggle any time.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         tack_armed_out <= 1'b0;
         tack_done_ff   <= 1'b0;
      end else if (state_ff == ST_IDLE) begin
         tack_armed_out <= tack_arm_toggle_in ? ~tack_armed_out : 1'b0;
         tack_done_ff   <= 1'b0;
      end else if (tack_arm_toggle_in) begin
         tack_armed_out <= ~tack_armed_out;
         tack_done_ff   <= 1'b1;
      end else if (!tack_done_ff && sensor_null_in && state_ff == ST_WELD) begin
         tack_armed_out <= run_flags[FLG_TACK];
         tack_done_ff   <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         slide_lockout_out <= 1'b0;
      end else begin
         slide_lockout_out <= tack_armed_out && tack_detect_in && state_ff != ST_IDLE;
      end
   end

   // Feature enables taken from the stored program; sidetrack stays on and drops at null outside idle only when its flag is set.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         sidetrack_en_out      <= 1'b1;
         z_search_en_out       <= 1'b0;
         vsearch_delay_en_out  <= 1'b0;
         hretract_delay_en_out <= 1'b0;
         settle_lockout_en_out <= 1'b0;
      end else begin
         sidetrack_en_out <= !(run_flags[FLG_SIDE] && sensor_null_in
                               && state_ff != ST_IDLE);
         z_search_en_out       <= run_flags[FLG_ZSRCH];
         vsearch_delay_en_out  <= run_flags[FLG_VDLY];
         hretract_delay_en_out <= run_flags[FLG_HDLY];
         settle_lockout_en_out <= run_flags[FLG_LOCK];
      end
   end

endmodule

// >>> wpf_feature_ctrl_props.sv
`timescale 1ns/100ps
module wpf_feature_ctrl_props
   import wpf_pkg::*;
#(
   parameter int TENTH_CYC = TENTH_CYCLES
) (
   input wire logic        ref_clk_in,
   input wire logic        rst_n_in,
   input wire logic        rd_strobe_in,
   input wire logic [31:0] rd_data_out,
   input wire logic        cycle_stop_in,
   input wire logic        sensor_null_in,
   input wire logic        tack_detect_in,
   input wire logic        tack_arm_toggle_in,
   input wire logic        weld_on_out,
   input wire logic        overlap_out,
   input wire logic        final_out,
   input wire logic        crater_out,
   input wire logic        retract_out,
   input wire logic        tack_armed_out,
   input wire logic        slide_lockout_out,
   input wire logic        sidetrack_en_out
);
   localparam int CRT_MIN = (CRATER_S * TENTHS_PER_S - 1) * TENTH_CYC;
   localparam int CRT_MAX = CRATER_S * TENTHS_PER_S * TENTH_CYC + 2;
   logic [4:0] phase_vec;
   int         crater_cnt_ff;

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   // Gathers the phase levels so they can be judged together.
   assign phase_vec = {weld_on_out, overlap_out, final_out, crater_out, retract_out};

   // Counts the cycles for which crater fill has been showing.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in || !crater_out) crater_cnt_ff <= 0;
      else crater_cnt_ff <= crater_cnt_ff + 1;
   end

   // An emergency stop empties the phases, then drops the tack arming.
   sequence s_stop_done;
      ##2 (phase_vec == 5'h00) ##1 !tack_armed_out;
   endsequence

   a_read_idle: assert property (!rd_strobe_in |=> rd_data_out == 32'h0)
      else $error("read data not zero without a read");
   a_phase_onehot: assert property ($onehot0(phase_vec))
      else $error("two cycle phases shown at once");
   a_stop_clears: assert property (cycle_stop_in |-> s_stop_done)
      else $error("stop did not return the cycle to idle");
   a_overlap_from_weld: assert property ($rose(overlap_out) |-> $past(weld_on_out))
      else $error("overlap entered from outside the weld phase");
   a_crater_order: assert property ($rose(crater_out) |-> $past(final_out))
      else $error("crater fill did not follow final time");
   a_retract_order: assert property ($rose(retract_out) |-> $past(final_out || crater_out))
      else $error("retract did not follow final or crater fill");
   a_crater_len: assert property ($fell(crater_out) |->
      crater_cnt_ff >= CRT_MIN && crater_cnt_ff <= CRT_MAX)
      else $error("crater fill length wrong");
   a_side_at_null: assert property ($fell(sidetrack_en_out) |-> $past(sensor_null_in))
      else $error("sidetrack dropped without null");
   a_arm_cause: assert property ($rose(tack_armed_out) |->
      $past(sensor_null_in) || $past(sensor_null_in, 2) ||
      $past(tack_arm_toggle_in) || $past(tack_arm_toggle_in, 2))
      else $error("tack armed without null or manual toggle");
   a_lock_clear: assert property ($fell(tack_detect_in) |=> !slide_lockout_out)
      else $error("slide lockout held after the tack passed");
endmodule

bind wpf_feature_ctrl wpf_feature_ctrl_props #(.TENTH_CYC(TENTH_CYC)) u_wpf_feature_ctrl_props (
   .ref_clk_in, .rst_n_in, .rd_strobe_in, .rd_data_out, .cycle_stop_in, .sensor_null_in,
   .tack_detect_in, .tack_arm_toggle_in, .weld_on_out, .overlap_out, .final_out, .crater_out,
   .retract_out, .tack_armed_out, .slide_lockout_out, .sidetrack_en_out);

// >>> wpf_sensor_model.sv
`timescale 1ns/100ps
module wpf_sensor_model #(
   parameter int SETTLE = 3
) (
   input  wire logic ref_clk_in,
   input  wire logic find_in,
   input  wire logic bump_in,
   input  wire logic dir_in,
   input  wire logic tack_in,
   output logic      sensor_null_out,
   output logic      sensor_up_out,
   output logic      sensor_down_out,
   output logic      tack_detect_out
);
   int settle_cnt;

   // Times how long the tip has sat in the seam before null is shown.
   always_ff @(posedge ref_clk_in) begin
      if (!find_in) settle_cnt <= 0;
      else if (settle_cnt < SETTLE) settle_cnt <= settle_cnt + 1;
   end

   // A bump leaves null and deflects the tip up or down; tacks are felt only on the seam.
   assign sensor_null_out = find_in && settle_cnt == SETTLE && !bump_in;
   assign sensor_up_out = bump_in && !dir_in;
   assign sensor_down_out = bump_in && dir_in;
   assign tack_detect_out = tack_in && find_in;
endmodule

// >>> weld_program_feature_control_tb.sv
`timescale 1ns/100ps
module weld_program_feature_control_tb;
   import wpf_pkg::*;
   localparam int TC = 10;
   localparam int DC = 4;
   logic        ref_clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic        wr_s = 1'b0;
   logic        rd_s = 1'b0;
   logic        btn = 1'b0;
   logic [7:0]  sw = 8'h00;
   logic        cstart = 1'b0;
   logic        cstop = 1'b0;
   logic        find = 1'b0;
   logic        bump = 1'b0;
   logic        dir = 1'b0;
   logic        tack = 1'b0;
   logic        tgl = 1'b0;
   logic [31:0] rd_data;
   logic        s_null, s_up, s_dn, s_tack;
   logic        weld_on, overlap, fin, crater, retract, armed, lock, side, zs, vd, hd, lk;
   logic [7:0]  differ, nsw;
   logic [4:0]  ph;
   logic [7:0]  mdl_flags [NUM_PROGS];
   int          mdl_weld [NUM_PROGS];
   logic [15:0] seed = 16'h2764;
   int          miscompares = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          t0, n, i;
   logic [31:0] d;

   // Free-running clock and a cycle count for measuring phases.
   initial forever #50 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) cyc <= cyc + 1;
   assign ph = {weld_on, overlap, fin, crater, retract};

   wpf_feature_ctrl #(.TENTH_CYC(TC), .DEB_CYC(DC)) u_wpf_feature_ctrl (
      .ref_clk_in, .rst_n_in, .addr_in(addr), .wr_data_in(wdat), .wr_strobe_in(wr_s),
      .rd_strobe_in(rd_s), .rd_data_out(rd_data), .prog_button_in(btn),
      .feature_select_switch_bank_in(sw), .cycle_start_in(cstart), .cycle_stop_in(cstop),
      .sensor_null_in(s_null), .sensor_up_in(s_up), .sensor_down_in(s_dn),
      .tack_detect_in(s_tack), .tack_arm_toggle_in(tgl), .weld_on_out(weld_on),
      .overlap_out(overlap), .final_out(fin), .crater_out(crater), .retract_out(retract),
      .tack_armed_out(armed), .slide_lockout_out(lock), .sidetrack_en_out(side),
      .z_search_en_out(zs), .vsearch_delay_en_out(vd), .hretract_delay_en_out(hd),
      .settle_lockout_en_out(lk), .features_differ_out(differ));

   wpf_sensor_model u_wpf_sensor_model (
      .ref_clk_in, .find_in(find), .bump_in(bump), .dir_in(dir), .tack_in(tack),
      .sensor_null_out(s_null), .sensor_up_out(s_up), .sensor_down_out(s_dn),
      .tack_detect_out(s_tack));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk_in);
      addr <= a;
      wdat <= v;
      wr_s <= 1'b1;
      @(posedge ref_clk_in);
      wr_s <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk_in);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge ref_clk_in);
      rd_s <= 1'b0;
      @(negedge ref_clk_in);
      v = rd_data;
   endtask

   // Holds the button long enough to pass the debouncer, then releases it as long.
   task automatic press();
      @(posedge ref_clk_in) btn <= 1'b1;
      repeat (DC + 6) @(posedge ref_clk_in);
      btn <= 1'b0;
      repeat (DC + 6) @(posedge ref_clk_in);
   endtask

   task automatic wait_ph(input int k, input logic v, input int lim);
      n = 0;
      while (ph[k] !== v && n < lim) begin
         @(negedge ref_clk_in);
         n++;
      end
   endtask

   task automatic start_cycle();
      @(posedge ref_clk_in) cstart <= 1'b1;
      @(posedge ref_clk_in);
      cstart <= 1'b0;
      find <= 1'b1;
      wait_ph(4, 1'b1, 50);
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Cuts a hung run short; the sequence needs under ten thousand cycles.
   initial begin
      #(20_000 * 100);
      miscompares++;
      complete_run();
   end

   // Main sequence: defaults, feature storing, a timed and an auto cutoff cycle.
   initial begin
      for (i = 0; i < NUM_PROGS; i++) begin
         mdl_flags[i] = DEF_FLAGS[i];
         mdl_weld[i] = DEF_WELD_S * TENTHS_PER_S;
      end
      repeat (4) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      for (i = 0; i < NUM_PROGS; i++) begin
         wr(REG_PROG_SEL, 32'(i));
         rd(REG_STATUS, d);
         chk(d[7:0], mdl_flags[i]);
         chk(d[FLG_AUTO], 32'(i >= 10));
         chk({lk, hd, vd, zs}, {mdl_flags[i][FLG_LOCK:FLG_VDLY], mdl_flags[i][FLG_ZSRCH]});
      end
      rd(8'h10, d);
      chk(d, 32'h0);
      // Fresh switches for program 1: timed ending, tack, sidetrack and crater on.
      wr(REG_PROG_SEL, 32'h0);
      wr(REG_TIMER_VAL, 32'h3);
      seed = lfsr(seed);
      nsw = (seed[7:0] & 8'h74) | 8'h89;
      sw <= nsw;
      press();
      rd(REG_STATUS, d);
      chk(d[ST_PEND_BIT], 1'b1);
      chk(differ, nsw ^ mdl_flags[0]);
      chk(d[7:0], mdl_flags[0]);
      press();
      mdl_flags[0] = nsw;
      mdl_weld[0] = 3;
      rd(REG_STATUS, d);
      chk({differ, d[ST_PEND_BIT], d[7:0]}, {9'h0, mdl_flags[0]});
      start_cycle();
      t0 = cyc;
      repeat (3) @(negedge ref_clk_in);
      chk({armed, side}, 2'b10);
      @(posedge ref_clk_in) tack <= 1'b1;
      repeat (3) @(negedge ref_clk_in);
      chk(lock, 1'b1);
      @(posedge ref_clk_in) tack <= 1'b0;
      repeat (3) @(negedge ref_clk_in);
      chk(lock, 1'b0);
      wait_ph(4, 1'b0, 100);
      n = cyc - t0;
      chk(32'(n >= (mdl_weld[0] - 1) * TC && n <= mdl_weld[0] * TC + 2), 1'b1);
      wait_ph(1, 1'b1, 200);
      chk(crater, 1'b1);
      wait_ph(0, 1'b1, 300);
      wait_ph(0, 1'b0, 100);
      chk(ph, 5'h00);
      @(posedge ref_clk_in) find <= 1'b0;
      // Program 12 ends its weld on the sensor after the stored time.
      wr(REG_PROG_SEL, 32'h0b);
      start_cycle();
      rd(REG_REMAIN, d);
      chk(32'(d[15:0] + 2 >= mdl_weld[11] && d[15:0] <= mdl_weld[11]), 1'b1);
      chk(armed, 1'b0);
      @(posedge ref_clk_in) tgl <= 1'b1;
      @(posedge ref_clk_in) tgl <= 1'b0;
      repeat (3) @(negedge ref_clk_in);
      chk(armed, 1'b1);
      // the stored weld time runs out before the seam ends.
      repeat (mdl_weld[11] * TC + 20) @(negedge ref_clk_in);
      rd(REG_STATUS, d);
      chk({d[ST_STATE_LSB +: 3], ph}, {3'h3, 5'h10});
      @(posedge ref_clk_in);
      bump <= 1'b1;
      dir <= seed[0];
      @(posedge ref_clk_in) bump <= 1'b0;
      wait_ph(3, 1'b1, 4);
      chk(overlap, 1'b1);
      @(posedge ref_clk_in) cstop <= 1'b1;
      @(posedge ref_clk_in) cstop <= 1'b0;
      repeat (4) @(negedge ref_clk_in);
      chk({ph, armed}, 6'h00);
      complete_run();
   end
endmodule
